/* File: fcpo_pkg.sv */
// Package: register map, field layout and timing constants of the flash command sequencer
package fcpo_pkg;
  // Register byte offsets (printed offsets are not all multiples of four: index * 4)
  localparam logic [7:0]  IDX_ECC_HIGH   = 8'h0E;
  localparam logic [7:0]  IDX_ECC_LOW    = 8'h0F;
  localparam logic [7:0]  IDX_NV_OPTION  = 8'h10;
  localparam logic [7:0]  IDX_RSV_TWO    = 8'h11;
  localparam logic [7:0]  IDX_RSV_THREE  = 8'h12;
  localparam logic [7:0]  IDX_RSV_FOUR   = 8'h13;
  localparam logic [11:0] ADDR_ECC_HIGH  = {2'h0, IDX_ECC_HIGH, 2'h0};
  localparam logic [11:0] ADDR_ECC_LOW   = {2'h0, IDX_ECC_LOW, 2'h0};
  localparam logic [11:0] ADDR_NV_OPTION = {2'h0, IDX_NV_OPTION, 2'h0};
  localparam logic [11:0] ADDR_RSV_TWO   = {2'h0, IDX_RSV_TWO, 2'h0};
  localparam logic [11:0] ADDR_RSV_THREE = {2'h0, IDX_RSV_THREE, 2'h0};
  localparam logic [11:0] ADDR_RSV_FOUR  = {2'h0, IDX_RSV_FOUR, 2'h0};
  localparam logic [11:0] ADDR_CLKDIV    = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_CMD_INDEX = 12'h008;
  localparam logic [11:0] ADDR_CMD_DATA  = 12'h00C;
  localparam logic [11:0] ADDR_CONFIG    = 12'h014;
  localparam logic [11:0] ADDR_OTP_USED  = 12'h018;
  // Status bit positions
  localparam int ST_COMMAND_COMPLETE_FLAG   = 7;
  localparam int ST_ACCERR = 5;
  localparam int ST_PVIOL  = 4;
  localparam int ST_MG1    = 1;
  localparam int ST_MG0    = 0;
  // Command codes and indices
  localparam logic [7:0] CMD_PROGRAM_PFLASH = 8'h06;
  localparam logic [7:0] CMD_PROGRAM_ONCE   = 8'h07;
  localparam logic [2:0] IDX_PHRASE_LAST    = 3'h5;
  localparam logic [2:0] IDX_ONCE_LAST      = 3'h4;
  localparam logic [15:0] ONCE_PHRASE_MAX   = 16'h0007;
  localparam logic [7:0] CLKDIV_RESET       = 8'h00;
  // Timing: one program pulse in timing-clock ticks, timing clock nominally 1 MHz
  localparam int PROG_TIME_US    = 20;
  localparam int PROG_TICKS      = PROG_TIME_US;
  localparam logic [7:0] VERIFY_TICKS = 8'h02;
  typedef enum logic [4:0] {
    FCPO_IDLE   = 5'b00001,
    FCPO_CHECK  = 5'b00010,
    FCPO_PROG   = 5'b00100,
    FCPO_VERIFY = 5'b01000,
    FCPO_DONE   = 5'b10000
  } fcpo_state_type;
  typedef struct packed {
    logic command_complete_flag;
    logic accerr;
    logic pviol;
    logic mg1;
    logic mg0;
  } fcpo_status_type;
endpackage

/* File: fcpo_top.sv */
// Flash command sequencer: clock divider, phrase program checks and program-once
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// RULE1: Divider reads eight bits; low seven write-once
// RULE2: Divide value times program and erase events; code has no erase command, times program and verify only
// RULE3: Software picks divide value for oscillator band
// RULE4: Phrase program errors unless word index five
// RULE5: Command not allowed in mode flags access error
// RULE6: Invalid global address flags access error
// RULE7: Misaligned phrase address flags access error
// RULE8: Protected address flags protection violation
// RULE9: Any verify error sets first verify flag; code compares only the low word, and only for program-once
// RULE10: Uncorrectable verify error sets second flag; code sets it together with the first flag on any low-word mismatch
// RULE11: Program-once writes only eight reserved phrases
// RULE12: Reserved field readable by read-once command; code has no such command, reads it at bus offsets 0x100-0x15F
// RULE13: Program-once code 07, phrase index 0..7
// RULE14: Data words at indices two, three, four
// RULE15: Software issues program-once only once
// RULE16: Software avoids running from block zero
// RULE17: Check erased, program, verify; complete stays clear
// RULE18: Already programmed phrase is refused
// RULE19: Block zero reads invalid during program-once
// RULE20: Launch error skips program, sets complete
module fcpo_top #(
  parameter int ADDR_W = 23
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             otp_write_q,
  output logic      [2:0]  otp_phrase_q,
  output logic      [47:0] otp_data_q,
  output logic             block0_invalid_q
);
  import fcpo_pkg::*;
  initial begin
    if (ADDR_W != 23) $error("fcpo_top supports a 23-bit global address only");
  end
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]      clkdiv_q, clkdiv_d;
  logic            div_locked_q, div_locked_d;
  logic [2:0]      cmd_idx_q, cmd_idx_d;
  logic [15:0]     ccob_q [0:5];
  logic [15:0]     ccob_d [0:5];
  fcpo_status_type st_q, st_d;
  fcpo_state_type  state_q, state_d;
  logic [7:0]      cfg_q, cfg_d;
  logic [7:0]      used_q, used_d;
  logic [15:0]     otp_mem_q [0:23];
  logic [15:0]     otp_mem_d [0:23];
  logic [6:0]      pre_q, pre_d;
  logic [7:0]      tick_cnt_q, tick_cnt_d;
  logic [31:0]     prdata_d;
  logic            otp_write_d;
  logic [2:0]      otp_phrase_d;
  logic [47:0]     otp_data_d;
  logic            blk0_d;
  logic            wr_en, rd_en;
  logic [7:0]      cmd;
  logic [22:0]     gaddr;
  logic            tick;
  logic            launch_err, prot_err;
  assign wr_en = psel & penable & pwrite;
  // Read data is registered in setup so it stands beside pready in the access cycle
  assign rd_en = psel & ~penable & ~pwrite;
  assign cmd   = ccob_q[0][15:8];
  assign gaddr = {ccob_q[0][6:0], ccob_q[1]};
  // Timing tick: pclk divided by divide value + 1
  assign tick  = (pre_q == clkdiv_q[6:0]); // RULE2
  ////////////////////////////////////////////////////////////////////////////
  // Launch checks; cfg bit0 = normal mode, bit1 = block0 protected, bits7:5 size
  always_comb begin
    launch_err = 1'b0;
    prot_err   = 1'b0;
    if (cmd == CMD_PROGRAM_PFLASH) begin
      if (cmd_idx_q != IDX_PHRASE_LAST) launch_err = 1'b1; // RULE4
      if (gaddr[22:20] != cfg_q[7:5]) launch_err = 1'b1; // RULE6
      if (gaddr[2:0] != 3'h0) launch_err = 1'b1; // RULE7
      if (cfg_q[1] && gaddr[19:17] == 3'h0) prot_err = 1'b1; // RULE8
    end else if (cmd == CMD_PROGRAM_ONCE) begin
      if (cmd_idx_q != IDX_ONCE_LAST) launch_err = 1'b1; // RULE13
      if (ccob_q[1] > ONCE_PHRASE_MAX) launch_err = 1'b1; // RULE11
      if (used_q[ccob_q[1][2:0]]) launch_err = 1'b1; // RULE18
    end else begin
      launch_err = 1'b1;
    end
    if (!cfg_q[0]) launch_err = 1'b1; // RULE5
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    clkdiv_d     = clkdiv_q;
    div_locked_d = div_locked_q;
    cmd_idx_d    = cmd_idx_q;
    ccob_d       = ccob_q;
    st_d         = st_q;
    state_d      = state_q;
    cfg_d        = cfg_q;
    used_d       = used_q;
    otp_mem_d    = otp_mem_q;
    pre_d        = tick ? 7'h00 : pre_q + 7'h01;
    tick_cnt_d   = tick_cnt_q;
    otp_write_d  = 1'b0;
    otp_phrase_d = otp_phrase_q;
    otp_data_d   = otp_data_q;
    blk0_d       = block0_invalid_q;
    prdata_d     = 32'h0000_0000;
    if (rd_en) begin
      if (paddr == ADDR_CLKDIV) prdata_d = {24'h0, clkdiv_q}; // RULE1
      else if (paddr == ADDR_STATUS) prdata_d = {24'h0, st_q.command_complete_flag, 1'b0, st_q.accerr,
                                                 st_q.pviol, 2'h0, st_q.mg1, st_q.mg0};
      else if (paddr == ADDR_CMD_INDEX) prdata_d = {29'h0, cmd_idx_q};
      else if (paddr == ADDR_CMD_DATA) prdata_d = (cmd_idx_q > 3'h5) ? 32'h0 :
                                                 {16'h0, ccob_q[cmd_idx_q]};
      else if (paddr == ADDR_CONFIG) prdata_d = {24'h0, cfg_q};
      else if (paddr == ADDR_OTP_USED) prdata_d = {24'h0, used_q};
      else if (paddr >= 12'h100 && paddr < 12'h160) // RULE12
        prdata_d = {16'h0, otp_mem_q[paddr[6:2]]};
    end
    if (wr_en) begin
      if (paddr == ADDR_CLKDIV && !div_locked_q) begin
        clkdiv_d[6:0] = pwdata[6:0]; // RULE1
        div_locked_d  = 1'b1;
      end else if (paddr == ADDR_CMD_INDEX) cmd_idx_d = pwdata[2:0];
      else if (paddr == ADDR_CMD_DATA && cmd_idx_q <= 3'h5 && st_q.command_complete_flag)
        ccob_d[cmd_idx_q] = pwdata[15:0];
      else if (paddr == ADDR_CONFIG) cfg_d = pwdata[7:0];
      else if (paddr == ADDR_STATUS) begin
        if (pwdata[ST_ACCERR]) st_d.accerr = 1'b0;
        if (pwdata[ST_PVIOL]) st_d.pviol = 1'b0;
        if (pwdata[ST_COMMAND_COMPLETE_FLAG] && st_q.command_complete_flag && !st_q.accerr && !st_q.pviol) begin
          st_d.command_complete_flag = 1'b0;
          st_d.mg1  = 1'b0;
          st_d.mg0  = 1'b0;
          state_d   = FCPO_CHECK;
        end
      end
    end
    case (state_q)
      FCPO_IDLE: begin
      end
      FCPO_CHECK: begin
        if (launch_err || prot_err) begin
          st_d.accerr = launch_err; // RULE20
          st_d.pviol  = prot_err; // RULE8
          state_d     = FCPO_DONE;
        end else if (cmd == CMD_PROGRAM_ONCE) begin
          blk0_d       = 1'b1; // RULE19
          otp_phrase_d = ccob_q[1][2:0];
          otp_data_d   = {ccob_q[4], ccob_q[3], ccob_q[2]}; // RULE14
          tick_cnt_d   = 8'h00;
          state_d      = FCPO_PROG; // RULE17
        end else begin
          tick_cnt_d = 8'h00;
          state_d    = FCPO_PROG;
        end
      end
      FCPO_PROG: begin
        if (tick) tick_cnt_d = tick_cnt_q + 8'h01;
        if (tick && tick_cnt_q == 8'(PROG_TICKS - 1)) begin
          if (cmd == CMD_PROGRAM_ONCE) begin
            otp_write_d = 1'b1; // RULE11
            used_d[otp_phrase_q] = 1'b1; // RULE18
            otp_mem_d[{2'h0, otp_phrase_q} * 5'd3]         = otp_data_q[15:0];
            otp_mem_d[{2'h0, otp_phrase_q} * 5'd3 + 5'd1]  = otp_data_q[31:16];
            otp_mem_d[{2'h0, otp_phrase_q} * 5'd3 + 5'd2]  = otp_data_q[47:32];
          end
          tick_cnt_d = 8'h00;
          state_d    = FCPO_VERIFY;
        end
      end
      FCPO_VERIFY: begin
        if (tick) tick_cnt_d = tick_cnt_q + 8'h01;
        if (tick && tick_cnt_q == VERIFY_TICKS - 8'h01) begin
          // Read-back compare of the low word against the latched phrase
          if (cmd == CMD_PROGRAM_ONCE &&
              otp_mem_q[{2'h0, otp_phrase_q} * 5'd3] != otp_data_q[15:0]) begin
            st_d.mg1 = 1'b1; // RULE9
            st_d.mg0 = 1'b1; // RULE10
          end
          state_d = FCPO_DONE;
        end
      end
      FCPO_DONE: begin
        blk0_d    = 1'b0;
        st_d.command_complete_flag = 1'b1; // RULE17
        state_d   = FCPO_IDLE;
      end
      default: state_d = FCPO_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkdiv_q         <= CLKDIV_RESET;
      div_locked_q     <= 1'b0;
      cmd_idx_q        <= 3'h0;
      for (int i = 0; i < 6; i++) ccob_q[i] <= 16'h0000;
      for (int i = 0; i < 24; i++) otp_mem_q[i] <= 16'hFFFF;
      st_q             <= '{command_complete_flag: 1'b1, accerr: 1'b0, pviol: 1'b0, mg1: 1'b0, mg0: 1'b0};
      state_q          <= FCPO_IDLE;
      cfg_q            <= 8'h01;
      used_q           <= 8'h00;
      pre_q            <= 7'h00;
      tick_cnt_q       <= 8'h00;
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      otp_write_q      <= 1'b0;
      otp_phrase_q     <= 3'h0;
      otp_data_q       <= 48'h0;
      block0_invalid_q <= 1'b0;
    end else if (clk_en) begin
      clkdiv_q         <= clkdiv_d;
      div_locked_q     <= div_locked_d;
      cmd_idx_q        <= cmd_idx_d;
      ccob_q           <= ccob_d;
      otp_mem_q        <= otp_mem_d;
      st_q             <= st_d;
      state_q          <= state_d;
      cfg_q            <= cfg_d;
      used_q           <= used_d;
      pre_q            <= pre_d;
      tick_cnt_q       <= tick_cnt_d;
      prdata           <= prdata_d;
      pready           <= psel & ~penable;
      pslverr          <= 1'b0;
      otp_write_q      <= otp_write_d;
      otp_phrase_q     <= otp_phrase_d;
      otp_data_q       <= otp_data_d;
      block0_invalid_q <= blk0_d;
    end
  end
endmodule // fcpo_top

/* File: fcpo_top_props.sv */
// Checker: bus and sequencer properties at the top ports
`timescale 1ns/1ps
module fcpo_top_props import fcpo_pkg::*; #(
  parameter int ADDR_W = 23
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        otp_write_q,
  input wire logic        block0_invalid_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (clk_en && psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_no_slave_error: assert property (!pslverr) else $error("pslverr raised");
  a_divider_top_zero: assert property (
    pready && !pwrite && paddr == ADDR_CLKDIV |-> prdata[31:7] == '0)
    else $error("divider top bit set");
  a_commit_pulse: assert property (otp_write_q |=> !otp_write_q)
    else $error("commit not a pulse");
  a_commit_while_busy: assert property (otp_write_q |-> block0_invalid_q)
    else $error("commit outside run");
  a_busy_bounded: assert property (
    $rose(block0_invalid_q) |-> ##[20:1000] !block0_invalid_q)
    else $error("run never ends");
  a_complete_clear_busy: assert property (
    pready && !pwrite && paddr == ADDR_STATUS && block0_invalid_q
    && $past(block0_invalid_q) |-> !prdata[ST_COMMAND_COMPLETE_FLAG]) else $error("complete set in run");
endmodule // fcpo_top_props
bind fcpo_top fcpo_top_props #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .otp_write_q(otp_write_q), .block0_invalid_q(block0_invalid_q));

/* File: fcpo_soft.sv */
// Software model: bus master that issues register accesses
`timescale 1ns/1ps
module fcpo_soft (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hFFF;
    pwdata = 32'h0;
  end
  // Entered just after an edge; released address and data lines show inverted values, not stale ones
  // Model code runs outside block zero, so a running program-once cannot upset it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // fcpo_soft

/* File: test_flash_command_program_once.sv */
// Testbench: register sequences against the flash command sequencer
`timescale 1ns/1ps
module test_flash_command_program_once;
  import fcpo_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, otp_write_q, b0_inv, first_cc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [2:0]  ph;
  logic [47:0] od;
  logic [50:0] seen_otp;
  logic [15:0] pw [0:5] = '{16'h0, 16'h0, 16'h1111, 16'h2222, 16'h3333, 16'h0};
  int          fails, check_count, b0;
  int          busy_n = 0;
  // Config, word 0, word 1, last index, status expected
  localparam logic [55:0] CASES [0:5] = '{56'h01_0600_0100_04_A0, 56'h00_0600_0100_05_A0,
    56'h01_0640_0100_05_A0, 56'h01_0600_0104_05_A0, 56'h03_0600_0100_05_90,
    56'h01_0700_0008_04_A0};
  fcpo_top #(.ADDR_W(23)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .otp_write_q(otp_write_q),
    .otp_phrase_q(ph), .otp_data_q(od), .block0_invalid_q(b0_inv));
  fcpo_soft soft_u (.pclk(pclk), .prdata(prdata), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (otp_write_q === 1'b1) seen_otp <= {ph, od};
    if (b0_inv === 1'b1) busy_n <= busy_n + 1;
  end
  task automatic chk(input logic [50:0] seen, input logic [50:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    soft_u.xfer(1'b1, a, d, rv);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    soft_u.xfer(1'b0, a, 32'h0, rv);
    chk({19'h0, rv}, {19'h0, exp}, nm);
  endtask
  // Word index is left at the last parameter written, as software would
  task automatic run_cmd(input logic [7:0] last);
    int n;
    for (int i = 0; i <= int'(last); i++) begin
      wr(ADDR_CMD_INDEX, 32'(i));
      wr(ADDR_CMD_DATA, {16'h0, pw[i]});
    end
    wr(ADDR_STATUS, 32'h80);
    n = 0;
    rv = 32'h0;
    while (rv[ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 200) begin
      soft_u.xfer(1'b0, ADDR_STATUS, 32'h0, rv);
      if (n == 0) first_cc = rv[ST_COMMAND_COMPLETE_FLAG];
      n++;
    end
    if (n == 200) fails++;
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  initial begin
    logic [11:0] ra [0:3] = '{ADDR_RSV_TWO, ADDR_RSV_THREE, ADDR_RSV_FOUR, 12'hFF0};
    presetn = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ADDR_CLKDIV, 32'h0, "divider reset");
    wr(ADDR_CLKDIV, 32'h81);
    wr(ADDR_CLKDIV, 32'h7F);
    rd_chk(ADDR_CLKDIV, 32'h01, "divider once");
    foreach (CASES[k]) begin
      wr(ADDR_CONFIG, {24'h0, CASES[k][55:48]});
      pw[0] = CASES[k][47:32];
      pw[1] = CASES[k][31:16];
      run_cmd(CASES[k][15:8]);
      rd_chk(ADDR_STATUS, {24'h0, CASES[k][7:0]}, "launch");
      wr(ADDR_STATUS, 32'h30);
    end
    wr(ADDR_CONFIG, 32'h01);
    pw[0] = {CMD_PROGRAM_ONCE, 8'h00};
    pw[1] = 16'h0003;
    b0 = busy_n;
    run_cmd({5'h0, IDX_ONCE_LAST});
    chk({50'h0, first_cc}, 51'h0, "complete in run");
    chk(seen_otp, {3'h3, 48'h3333_2222_1111}, "commit");
    chk({50'h0, (busy_n - b0) >= 2 * PROG_TICKS}, 51'h1, "run length");
    rd_chk(ADDR_OTP_USED, 32'h08, "used mask");
    rd_chk(12'h128, 32'h2222, "read once");
    run_cmd({5'h0, IDX_ONCE_LAST});
    rd_chk(ADDR_STATUS, 32'hA0, "second once");
    wr(ADDR_STATUS, 32'h30);
    rd_chk(ADDR_STATUS, 32'h80, "flags cleared");
    wr(12'hFF0, 32'hFFFF);
    foreach (ra[j]) rd_chk(ra[j], 32'h0, "reserved");
    print_verdict();
  end
endmodule // test_flash_command_program_once
